// *** hw/sacc_core.sv ***
// Converter configuration registers and measurement sequencer
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "sacc_regs.svh"

module sacc_core
  import sacc_pkg::*;
#(
  parameter int INTEG_ADC_CLKS = `SACC_INTEG_ADC_CLKS,
  parameter int CNT_W = 10
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  output logic [7:0] o_reg_rdata,
  // Measurement request
  input wire logic i_meas_valid,
  input wire sacc_kind_t i_meas_kind,
  output logic o_meas_ready,
  output logic o_meas_done,
  // Converter front end
  output logic [7:0] o_adc_sel,
  output logic [2:0] o_adc_gain,
  output logic o_adc_integrate,
  output logic o_adc_tick,
  output logic o_high_range,
  output logic o_emitter_on,
  // Configuration views
  output logic [2:0] o_prox_gain_exponent,
  output logic o_prox_high_range,
  output logic o_prox_channel_mode,
  output logic [7:0] o_ambient_ir_input_select,
  output logic [7:0] o_auxiliary_input_select,
  output logic [2:0] o_visible_recovery_count,
  output logic [2:0] o_visible_gain_exponent
);

  sacc_core_st_t st_q;
  sacc_core_st_t st_d;
  logic tmr_busy;
  logic tmr_tick;
  logic tmr_done;

  localparam logic [CNT_W-1:0] INTEG_CNT = CNT_W'(INTEG_ADC_CLKS);

  // ============================================================
  // Helpers
  function automatic logic [CNT_W-1:0] rec_clks(input logic [2:0] code);
    logic [CNT_W-1:0] one;
    one = CNT_W'(1);
    if (code == 3'h0) begin
      rec_clks = one;
    end else begin
      rec_clks = (one << ({1'b0, code} + 4'h2)) - one;
    end
  endfunction

  function automatic sacc_cfg_t cfg_reset();
    sacc_cfg_t c;
    c.prox_gain = `SACC_RST_PROX_GAIN;
    c.prox_misc = `SACC_RST_PROX_MISC;
    c.ir_input = `SACC_RST_IR_INPUT;
    c.aux_input = `SACC_RST_AUX_INPUT;
    c.vis_rec = `SACC_RST_VIS_REC;
    c.vis_gain = `SACC_RST_VIS_GAIN;
    cfg_reset = c;
  endfunction

  localparam sacc_cfg_t CFG_RST = cfg_reset();

  function automatic logic [7:0] read_mux(
    input logic [7:0] addr,
    input sacc_cfg_t c,
    input logic [7:0] status
  );
    read_mux = 8'h00;
    unique case (addr)
      `SACC_ADDR_PROX_GAIN: read_mux = c.prox_gain;
      `SACC_ADDR_PROX_MISC: read_mux = c.prox_misc;
      `SACC_ADDR_IR_INPUT: read_mux = c.ir_input;
      `SACC_ADDR_AUX_INPUT: read_mux = c.aux_input;
      `SACC_ADDR_VIS_REC: read_mux = c.vis_rec;
      `SACC_ADDR_VIS_GAIN: read_mux = c.vis_gain;
      `SACC_ADDR_STATUS: read_mux = status;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // ============================================================
  // Converter clock timer
  sacc_timer #(
    .DIV_W(11),
    .CNT_W(CNT_W)
  ) u_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(st_q.tmr_start),
    .i_gain(st_q.gain),
    .i_count(st_q.tmr_count),
    .o_busy(tmr_busy),
    .o_tick(tmr_tick),
    .o_done(tmr_done)
  );

  // ============================================================
  // Next state
  always_comb begin
    logic [7:0] status;
    status = {5'h00, st_q.emit, st_q.integ,
      (st_q.state != SACC_IDLE) || tmr_busy};
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.tmr_start = 1'b0;

    // Register writes, reserved bits masked
    if (i_reg_we) begin
      unique case (i_reg_addr)
        `SACC_ADDR_PROX_GAIN: begin
          st_d.cfg.prox_gain = i_reg_wdata & `SACC_MASK_GAIN;
        end
        `SACC_ADDR_PROX_MISC: begin
          st_d.cfg.prox_misc = i_reg_wdata & `SACC_MASK_PROX_MISC;
        end
        `SACC_ADDR_IR_INPUT: begin
          st_d.cfg.ir_input = i_reg_wdata & `SACC_MASK_FULL;
        end
        `SACC_ADDR_AUX_INPUT: begin
          st_d.cfg.aux_input = i_reg_wdata & `SACC_MASK_FULL;
        end
        `SACC_ADDR_VIS_REC: begin
          st_d.cfg.vis_rec = i_reg_wdata & `SACC_MASK_VIS_REC;
        end
        `SACC_ADDR_VIS_GAIN: begin
          st_d.cfg.vis_gain = i_reg_wdata & `SACC_MASK_GAIN;
        end
        default: begin
        end
      endcase
    end

    // Read data, valid the cycle after the strobe
    if (i_reg_re) begin
      st_d.rdata = read_mux(i_reg_addr, st_q.cfg, status);
    end else begin
      st_d.rdata = 8'h00;
    end

    // Measurement sequencer
    unique case (st_q.state)
      SACC_IDLE: begin
        if (i_meas_valid) begin
          st_d.kind = i_meas_kind;
          st_d.tmr_start = 1'b1;
          st_d.tmr_count = INTEG_CNT;
          st_d.high_range = 1'b0;
          st_d.emit = 1'b0;
          unique case (i_meas_kind)
            SACC_PROX: begin
              st_d.gain = st_q.cfg.prox_gain[`SACC_GAIN_MSB:0];
              st_d.adc_sel = `SACC_IN_LARGE_IR;
              st_d.high_range =
                st_q.cfg.prox_misc[`SACC_PROX_RANGE_BIT];
              st_d.emit =
                st_q.cfg.prox_misc[`SACC_PROX_MODE_BIT];
              st_d.integ = 1'b1;
              st_d.state = SACC_CONVERT;
            end
            SACC_VIS: begin
              st_d.gain = st_q.cfg.vis_gain[`SACC_GAIN_MSB:0];
              st_d.adc_sel = `SACC_IN_VISIBLE;
              st_d.tmr_count = rec_clks(
                st_q.cfg.vis_rec[`SACC_VIS_REC_MSB:`SACC_VIS_REC_LSB]);
              st_d.state = SACC_RECOVER;
            end
            SACC_IR: begin
              st_d.gain = 3'h0;
              st_d.adc_sel = st_q.cfg.ir_input;
              st_d.integ = 1'b1;
              st_d.state = SACC_CONVERT;
            end
            SACC_AUX: begin
              st_d.gain = 3'h0;
              st_d.adc_sel = st_q.cfg.aux_input;
              st_d.integ = 1'b1;
              st_d.state = SACC_CONVERT;
            end
          endcase
        end
      end
      SACC_RECOVER: begin
        if (tmr_done) begin
          st_d.tmr_start = 1'b1;
          st_d.tmr_count = INTEG_CNT;
          st_d.integ = 1'b1;
          st_d.state = SACC_CONVERT;
        end
      end
      SACC_CONVERT: begin
        if (tmr_done) begin
          st_d.integ = 1'b0;
          st_d.emit = 1'b0;
          st_d.high_range = 1'b0;
          st_d.done = 1'b1;
          st_d.state = SACC_IDLE;
        end
      end
    endcase
  end

  // ============================================================
  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
      st_q.cfg <= CFG_RST;
      st_q.state <= SACC_IDLE;
      st_q.kind <= SACC_PROX;
    end else begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Outputs
  assign o_reg_rdata = st_q.rdata;
  assign o_meas_ready = (st_q.state == SACC_IDLE);
  assign o_meas_done = st_q.done;
  assign o_adc_sel = st_q.adc_sel;
  assign o_adc_gain = st_q.gain;
  assign o_adc_integrate = st_q.integ;
  assign o_adc_tick = tmr_tick;
  assign o_high_range = st_q.high_range;
  assign o_emitter_on = st_q.emit & st_q.integ;
  assign o_prox_gain_exponent = st_q.cfg.prox_gain[`SACC_GAIN_MSB:0];
  assign o_prox_high_range = st_q.cfg.prox_misc[`SACC_PROX_RANGE_BIT];
  assign o_prox_channel_mode = st_q.cfg.prox_misc[`SACC_PROX_MODE_BIT];
  assign o_ambient_ir_input_select = st_q.cfg.ir_input;
  assign o_auxiliary_input_select = st_q.cfg.aux_input;
  assign o_visible_recovery_count =
    st_q.cfg.vis_rec[`SACC_VIS_REC_MSB:`SACC_VIS_REC_LSB];
  assign o_visible_gain_exponent = st_q.cfg.vis_gain[`SACC_GAIN_MSB:0];

endmodule

// *** hw/sacc_pkg.sv ***
// Types shared by the converter configuration block
package sacc_pkg;

  typedef enum logic [1:0] {
    SACC_PROX,
    SACC_VIS,
    SACC_IR,
    SACC_AUX
  } sacc_kind_t;

  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_RECOVER,
    SACC_CONVERT
  } sacc_state_t;

  typedef struct packed {
    logic [7:0] prox_gain;
    logic [7:0] prox_misc;
    logic [7:0] ir_input;
    logic [7:0] aux_input;
    logic [7:0] vis_rec;
    logic [7:0] vis_gain;
  } sacc_cfg_t;

  typedef struct packed {
    sacc_cfg_t cfg;
    sacc_state_t state;
    sacc_kind_t kind;
    logic [7:0] rdata;
    logic done;
    logic emit;
    logic integ;
    logic high_range;
    logic [7:0] adc_sel;
    logic [2:0] gain;
    logic tmr_start;
    logic [9:0] tmr_count;
  } sacc_core_st_t;

  typedef struct packed {
    logic running;
    logic [2:0] gain;
    logic [10:0] div;
    logic [9:0] ticks;
    logic tick;
    logic done;
  } sacc_tmr_st_t;

endpackage

// *** hw/sacc_regs.svh ***
// Register offsets, field layouts, reset values and timing counts
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH

// ============================================================
// Register offsets
`define SACC_ADDR_PROX_GAIN 8'h0b
`define SACC_ADDR_PROX_MISC 8'h0c
`define SACC_ADDR_IR_INPUT 8'h0e
`define SACC_ADDR_AUX_INPUT 8'h0f
`define SACC_ADDR_VIS_REC 8'h10
`define SACC_ADDR_VIS_GAIN 8'h11
`define SACC_ADDR_STATUS 8'h13

// ============================================================
// Reset values
`define SACC_RST_PROX_GAIN 8'h00
`define SACC_RST_PROX_MISC 8'h04
`define SACC_RST_IR_INPUT 8'h00
`define SACC_RST_AUX_INPUT 8'h65
`define SACC_RST_VIS_REC 8'h70
`define SACC_RST_VIS_GAIN 8'h00

// ============================================================
// Writable bit masks
`define SACC_MASK_GAIN 8'h07
`define SACC_MASK_PROX_MISC 8'h24
`define SACC_MASK_VIS_REC 8'h70
`define SACC_MASK_FULL 8'hff

// ============================================================
// Field positions
`define SACC_GAIN_MSB 2
`define SACC_PROX_RANGE_BIT 5
`define SACC_PROX_MODE_BIT 2
`define SACC_VIS_REC_MSB 6
`define SACC_VIS_REC_LSB 4

// ============================================================
// Converter input codes
`define SACC_IN_SMALL_IR 8'h00
`define SACC_IN_VISIBLE 8'h02
`define SACC_IN_LARGE_IR 8'h03
`define SACC_IN_TEMP 8'h65
`define SACC_IN_VDD 8'h75

// ============================================================
// Timing
`define SACC_CLK_NS 4
`define SACC_ADC_CLK_NS 50
`define SACC_ADC_CLK_CYC ((`SACC_ADC_CLK_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)
`define SACC_INTEG_ADC_CLKS 512

`endif

// *** hw/sacc_timer.sv ***
// Converter clock divider and tick counter
`timescale 1ns/100ps
`include "sacc_regs.svh"

module sacc_timer
  import sacc_pkg::*;
#(
  parameter int DIV_W = 11,
  parameter int CNT_W = 10
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [2:0] i_gain,
  input wire logic [CNT_W-1:0] i_count,
  output logic o_busy,
  output logic o_tick,
  output logic o_done
);

  sacc_tmr_st_t st_q;
  sacc_tmr_st_t st_d;

  // ============================================================
  // Cycles per converter clock, scaled by the gain exponent
  function automatic logic [DIV_W-1:0] tick_len(input logic [2:0] gain);
    logic [DIV_W-1:0] base;
    base = DIV_W'(`SACC_ADC_CLK_CYC);
    tick_len = base << gain;
  endfunction

  // ============================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    st_d.done = 1'b0;
    if (i_start) begin
      st_d.running = 1'b1;
      st_d.gain = i_gain;
      st_d.div = tick_len(i_gain) - DIV_W'(1);
      st_d.ticks = (i_count == '0) ? CNT_W'(1) : i_count;
    end else if (st_q.running) begin
      if (st_q.div == '0) begin
        st_d.tick = 1'b1;
        st_d.div = tick_len(st_q.gain) - DIV_W'(1);
        if (st_q.ticks == CNT_W'(1)) begin
          st_d.running = 1'b0;
          st_d.done = 1'b1;
        end else begin
          st_d.ticks = st_q.ticks - CNT_W'(1);
        end
      end else begin
        st_d.div = st_q.div - DIV_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_busy = st_q.running;
  assign o_tick = st_q.tick;
  assign o_done = st_q.done;

endmodule

// *** verif/sacc_core_sva.sv ***
// Concurrent checks on the converter configuration block
`timescale 1ns/100ps
module sacc_core_sva
  import sacc_pkg::*;
#(
  parameter int INTEG_ADC_CLKS = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_reg_re,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_meas_valid,
  input wire sacc_kind_t i_meas_kind,
  input wire logic o_meas_ready,
  input wire logic o_meas_done,
  input wire logic [7:0] o_adc_sel,
  input wire logic [2:0] o_adc_gain,
  input wire logic o_adc_integrate,
  input wire logic o_high_range,
  input wire logic o_emitter_on,
  input wire logic [2:0] o_prox_gain_exponent,
  input wire logic o_prox_high_range,
  input wire logic o_prox_channel_mode,
  input wire logic [7:0] o_ambient_ir_input_select,
  input wire logic [7:0] o_auxiliary_input_select
);
  // ============================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic tk;
  assign tk = i_meas_valid && o_meas_ready;
  a_prox_gain: assert property (tk && i_meas_kind == SACC_PROX
    |=> o_adc_gain == $past(o_prox_gain_exponent)) else $error("bad gain");
  a_prox_range: assert property (tk && i_meas_kind == SACC_PROX
    |=> o_high_range == $past(o_prox_high_range)) else $error("bad range");
  a_prox_emit: assert property (tk && i_meas_kind == SACC_PROX
    && o_prox_channel_mode |=> o_emitter_on && o_adc_integrate
    && o_adc_sel == 8'h03) else $error("no emitter");
  a_raw_dark: assert property (tk && i_meas_kind == SACC_PROX
    && !o_prox_channel_mode |=> !o_emitter_on [*8]) else $error("emitter");
  a_ir_input: assert property (tk && i_meas_kind == SACC_IR
    |=> o_adc_sel == $past(o_ambient_ir_input_select)) else $error("ir sel");
  a_aux_input: assert property (tk && i_meas_kind == SACC_AUX
    |=> o_adc_sel == $past(o_auxiliary_input_select)) else $error("aux sel");
  a_vis_wait: assert property (tk && i_meas_kind == SACC_VIS
    |=> !o_adc_integrate [*8]) else $error("no recovery");
  a_integ_end: assert property ($fell(o_adc_integrate)
    |-> o_meas_done) else $error("integrate end");
  a_rdata_idle: assert property (!i_reg_re
    |=> o_reg_rdata == 8'h00) else $error("rdata not idle");
endmodule

bind sacc_core sacc_core_sva #(.INTEG_ADC_CLKS(INTEG_ADC_CLKS)) u_sva (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_re(i_reg_re),
  .o_reg_rdata(o_reg_rdata), .i_meas_valid(i_meas_valid),
  .i_meas_kind(i_meas_kind), .o_meas_ready(o_meas_ready),
  .o_meas_done(o_meas_done), .o_adc_sel(o_adc_sel),
  .o_adc_gain(o_adc_gain), .o_adc_integrate(o_adc_integrate),
  .o_high_range(o_high_range), .o_emitter_on(o_emitter_on),
  .o_prox_gain_exponent(o_prox_gain_exponent),
  .o_prox_high_range(o_prox_high_range),
  .o_prox_channel_mode(o_prox_channel_mode),
  .o_ambient_ir_input_select(o_ambient_ir_input_select),
  .o_auxiliary_input_select(o_auxiliary_input_select)
);

// *** verif/sacc_host.sv ***
// Host model that programs the configuration registers
`timescale 1ns/100ps
module sacc_host (
  input wire logic i_clk,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_we,
  output logic o_re,
  input wire logic [7:0] i_rdata
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_we = 1'b0;
    o_re = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    if (a == 8'h0b && d[2:0] > 3'h5) begin
      d[2:0] = 3'h5;
    end
    o_we <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_re <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_re <= 1'b0;
    #1;
    d = i_rdata;
  endtask
  task automatic vis_cfg(input logic [2:0] g);
    wr(8'h11, {5'h00, g});
    wr(8'h10, {1'b0, ~g, 4'h0});
  endtask
endmodule

// *** verif/tb_sensor_adc_channel_config.sv ***
// Self-checking bench for the converter configuration block
`timescale 1ns/100ps
module tb_sensor_adc_channel_config;
  import sacc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, sel, adc_sel;
  logic we, re, valid = 1'b0, ready, done, emit, hr, emit_seen;
  logic hr_seen, tick;
  logic [2:0] vrc, vge;
  sacc_kind_t kind = SACC_PROX;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  int ticks;
  always #2 clk = ~clk;
  sacc_host u_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata),
    .o_we(we), .o_re(re), .i_rdata(rdata));
  sacc_core #(.INTEG_ADC_CLKS(4)) DUT (.i_clk(clk), .i_rstn(rstn),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_we(we), .i_reg_re(re),
    .o_reg_rdata(rdata), .i_meas_valid(valid), .i_meas_kind(kind),
    .o_meas_ready(ready), .o_meas_done(done), .o_adc_sel(adc_sel),
    .o_adc_gain(), .o_adc_integrate(), .o_adc_tick(tick), .o_high_range(hr),
    .o_emitter_on(emit), .o_prox_gain_exponent(), .o_prox_high_range(),
    .o_prox_channel_mode(), .o_ambient_ir_input_select(),
    .o_auxiliary_input_select(), .o_visible_recovery_count(vrc),
    .o_visible_gain_exponent(vge));
  // ============================================================
  // Helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic meas(input sacc_kind_t k, input int e);
    @(posedge clk);
    valid <= 1'b1;
    kind <= k;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    sel = adc_sel;
    hr_seen = hr;
    emit_seen = emit;
    ticks = 0;
    n = 1;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
      if (emit === 1'b1) emit_seen = 1'b1;
      if (tick === 1'b1) ticks++;
    end
    chk((n >= e && n <= e + 5) ? e[15:0] : n[15:0], e[15:0]);
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset;
    rdchk(8'h0b, 8'h00);
    rdchk(8'h0c, 8'h04);
    rdchk(8'h0e, 8'h00);
    rdchk(8'h0f, 8'h65);
    rdchk(8'h10, 8'h70);
  endtask
  task automatic t_mask;
    u_host.wr(8'h0c, 8'hff);
    rdchk(8'h0c, 8'h24);
    u_host.wr(8'h10, 8'hff);
    rdchk(8'h10, 8'h70);
    u_host.wr(8'h0b, 8'hfd);
    rdchk(8'h0b, 8'h05);
    rdchk(8'h20, 8'h00);
  endtask
  task automatic t_prox;
    logic [2:0] gl [3] = '{3'h0, 3'h4, 3'h5};
    foreach (gl[i]) begin
      u_host.wr(8'h0b, {5'h00, gl[i]});
      meas(SACC_PROX, 52 << gl[i]);
      chk(ticks[15:0], 16'h0004);
      chk({8'h00, sel}, 16'h0003);
    end
  endtask
  task automatic t_mode;
    u_host.wr(8'h0b, 8'h00);
    u_host.wr(8'h0c, 8'h24);
    meas(SACC_PROX, 52);
    chk({15'h0, hr_seen}, 16'h0001);
    chk({15'h0, emit_seen}, 16'h0001);
    u_host.wr(8'h0c, 8'h20);
    meas(SACC_PROX, 52);
    chk({15'h0, emit_seen}, 16'h0000);
    u_host.wr(8'h0c, 8'h04);
    meas(SACC_PROX, 52);
    chk({15'h0, hr_seen}, 16'h0000);
  endtask
  task automatic t_sel;
    u_host.wr(8'h0e, 8'h03);
    meas(SACC_IR, 52);
    chk({8'h00, sel}, 16'h0003);
    u_host.wr(8'h0e, 8'h00);
    meas(SACC_IR, 52);
    chk({8'h00, sel}, 16'h0000);
    u_host.wr(8'h0f, 8'h75);
    meas(SACC_AUX, 52);
    chk({8'h00, sel}, 16'h0075);
    u_host.wr(8'h0f, 8'h65);
    meas(SACC_AUX, 52);
    chk({8'h00, sel}, 16'h0065);
  endtask
  task automatic t_vis;
    u_host.vis_cfg(3'h0);
    meas(SACC_VIS, 515 * 13);
    chk(ticks[15:0], 16'h0203);
    u_host.vis_cfg(3'h7);
    meas(SACC_VIS, 5 * 13 * 128);
    chk(ticks[15:0], 16'h0005);
    u_host.vis_cfg(3'h2);
    #1;
    chk({13'h0, vrc}, 16'h0005);
    chk({13'h0, vge}, 16'h0002);
    meas(SACC_VIS, 131 * 52);
    chk(ticks[15:0], 16'h0083);
    u_host.wr(8'h10, 8'h30);
    meas(SACC_VIS, 35 * 52);
    chk(ticks[15:0], 16'h0023);
  endtask
  // ============================================================
  // Main sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_mask();
    t_prox();
    t_mode();
    t_sel();
    t_vis();
    wrap_up();
  end
endmodule
